// ---- hdl/ubl_pkg.sv ----
// Constants for the baud divisor and line-control block.
// Assumes a 32-bit register port with byte addresses.
package ubl_pkg;
	localparam int UBL_DATA_W = 32;
	localparam int UBL_INT_W = 16;
	localparam int UBL_FRAC_W = 6;
	localparam int UBL_LCR_W = 8;
	localparam int UBL_CNT_W = UBL_INT_W + 1;
	localparam int UBL_OVERSAMPLE = 16;
	localparam int UBL_FRAC_UNITS = 64;

	localparam logic [7:0] UBL_OFS_INT = 8'h00;
	localparam logic [7:0] UBL_OFS_FRAC = 8'h04;
	localparam logic [7:0] UBL_OFS_LCR = 8'h08;
	localparam logic [7:0] UBL_OFS_STATUS = 8'h0C;

	localparam logic [UBL_INT_W-1:0] UBL_INT_RESET = 16'h0000;
	localparam logic [UBL_FRAC_W-1:0] UBL_FRAC_RESET = 6'h00;
	localparam logic [UBL_LCR_W-1:0] UBL_LCR_RESET = 8'h00;
	localparam logic [UBL_INT_W-1:0] UBL_INT_MAX = 16'hFFFF;

	localparam int UBL_BIT_STICK = 7;
	localparam int UBL_BIT_WL_HI = 6;
	localparam int UBL_BIT_WL_LO = 5;
	localparam int UBL_BIT_FIFO_EN = 4;
	localparam int UBL_BIT_TWO_STOP = 3;
	localparam int UBL_BIT_EVEN = 2;
	localparam int UBL_BIT_PAR_EN = 1;
	localparam int UBL_BIT_BREAK = 0;

	localparam int UBL_BIT_PENDING = 0;
	localparam int UBL_BIT_ZERO_DIV = 1;
	localparam int UBL_BIT_BAD_FRAC = 2;

	localparam logic [3:0] UBL_MIN_DATA_BITS = 4'h5;
endpackage

// ---- hdl/ubl_baud_gen.sv ----
// Fractional divider making the 16x bit-rate tick.
// Assumes divisor inputs change only together with the load pulse.
`timescale 1ns/1ns
module ubl_baud_gen
	import ubl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [UBL_INT_W-1:0] divInt,
	input wire logic [UBL_FRAC_W-1:0] divFrac,
	output logic baudTick
);
	logic [UBL_CNT_W-1:0] cnt_reg;
	logic [UBL_CNT_W-1:0] cnt_next;
	logic [UBL_FRAC_W-1:0] acc_reg;
	logic [UBL_FRAC_W-1:0] acc_next;
	wire logic divOn;
	wire logic [UBL_FRAC_W:0] fracSum;
	wire logic carry;
	wire logic [UBL_CNT_W-1:0] reloadVal;

	assign divOn = (divInt != UBL_INT_RESET);
	assign fracSum = {1'b0, acc_reg} + {1'b0, divFrac};
	assign carry = fracSum[UBL_FRAC_W];
	assign reloadVal = UBL_CNT_W'({1'b0, divInt} - 17'h00001 + {16'h0000, carry});
	assign baudTick = divOn && !load && (cnt_reg == '0);

	always_comb
	begin
		cnt_next = cnt_reg;
		acc_next = acc_reg;
		if (load || !divOn)
		begin
			cnt_next = '0;
			acc_next = '0;
		end
		else if (baudTick)
		begin
			cnt_next = reloadVal;
			acc_next = fracSum[UBL_FRAC_W-1:0];
		end
		else
			cnt_next = cnt_reg - 17'h00001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			cnt_reg <= '0;
			acc_reg <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			acc_reg <= acc_next;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_zero_no_tick: assert property (divInt == UBL_INT_RESET |-> !baudTick)
		else $error("tick with zero integer divisor");
	a_tick_period: assert property ((baudTick && divInt == 16'h0004 && divFrac == 6'h00)
		##1 (!load)[*3] |=> baudTick)
		else $error("tick period wrong for divisor four");
	a_frac_accum: assert property (baudTick |=> acc_reg == $past(fracSum[UBL_FRAC_W-1:0])
		|| $past(load))
		else $error("fraction accumulator not advanced");
endmodule

// ---- hdl/ubl_frame_cfg.sv ----
// Decodes the committed line-control word into framing settings.
// Assumes the shifters read these outputs at character boundaries.
`timescale 1ns/1ns
module ubl_frame_cfg
	import ubl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [UBL_LCR_W-1:0] lineCtrl,
	output logic [3:0] dataBits,
	output logic parityOn,
	output logic parityEven,
	output logic parityStick,
	output logic stickValue,
	output logic twoStopBits,
	output logic fifoEnable,
	output logic sendBreak
);
	function automatic logic [3:0] wordBits(input logic [1:0] code);
		wordBits = UBL_MIN_DATA_BITS + {2'b00, code};
	endfunction

	wire logic [1:0] wlCode;
	wire logic stickSel;
	assign wlCode = {lineCtrl[UBL_BIT_WL_HI], lineCtrl[UBL_BIT_WL_LO]};
	assign stickSel = lineCtrl[UBL_BIT_PAR_EN] && lineCtrl[UBL_BIT_STICK];

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			dataBits <= UBL_MIN_DATA_BITS;
			parityOn <= 1'b0;
			parityEven <= 1'b0;
			parityStick <= 1'b0;
			stickValue <= 1'b0;
			twoStopBits <= 1'b0;
			fifoEnable <= 1'b0;
			sendBreak <= 1'b0;
		end
		else
		begin
			dataBits <= wordBits(wlCode);
			parityOn <= lineCtrl[UBL_BIT_PAR_EN];
			parityEven <= lineCtrl[UBL_BIT_EVEN];
			parityStick <= stickSel;
			stickValue <= !lineCtrl[UBL_BIT_EVEN];
			twoStopBits <= lineCtrl[UBL_BIT_TWO_STOP];
			fifoEnable <= lineCtrl[UBL_BIT_FIFO_EN];
			sendBreak <= lineCtrl[UBL_BIT_BREAK];
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_word_length: assert property (##1 dataBits == wordBits($past(wlCode)))
		else $error("data bit count does not follow word length code");
	a_stick_value: assert property (stickSel |=> parityStick
		&& stickValue == !$past(lineCtrl[UBL_BIT_EVEN]))
		else $error("stick parity value wrong");
	a_parity_enable: assert property (!lineCtrl[UBL_BIT_PAR_EN] |=> !parityOn && !parityStick)
		else $error("parity active while disabled");
endmodule

// ---- hdl/ubl_top.sv ----
// Baud divisor and line-control registers with the bit-rate tick generator.
// Assumes shifters report character activity on the same clock.
// Operation
// - Sixteen-bit integer divisor, software read and write, resets to zero.
// - Six-bit fractional divisor, software read and write, resets to zero.
// - Reference clock divided by integer plus fraction gives the 16x tick.
// - New divisor values take effect only between characters.
// - Ratio 1 to 65535; zero integer divisor stops the tick, fraction ignored.
// - Fraction counts sixty-fourths, error spread over sixty-four ticks.
// - Line-control word has its own register at offset 08, bits 7 to 0, resets zero.
// - Line-control bits 15 to 8 read zero; software leaves them alone.
// - Stick parity sends and checks 0 when even set, 1 when clear.
// - Word length code 11 gives eight data bits, 10 gives seven.
// - All three values commit together once a line-control write has armed the commit and no character is active.
// - Parity enable turns parity on; even select picks even or odd.
`timescale 1ns/1ns
module ubl_top
	import ubl_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [UBL_DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [UBL_DATA_W-1:0] regRdata,
	input wire logic txBusy,
	input wire logic rxBusy,
	output logic baudTick,
	output logic commitPulse,
	output logic divisorInvalid,
	output logic [3:0] dataBits,
	output logic parityOn,
	output logic parityEven,
	output logic parityStick,
	output logic stickValue,
	output logic twoStopBits,
	output logic fifoEnable,
	output logic sendBreak
);
	if (ADDR_W < 4 || ADDR_W > 8)
		$error("ADDR_W must be 4 to 8");

	logic [UBL_INT_W-1:0] intShadow_reg;
	logic [UBL_FRAC_W-1:0] fracShadow_reg;
	logic [UBL_LCR_W-1:0] lcrShadow_reg;
	logic [UBL_INT_W-1:0] intLive_reg;
	logic [UBL_FRAC_W-1:0] fracLive_reg;
	logic [UBL_LCR_W-1:0] lcrLive_reg;
	logic pending_reg;
	logic pending_next;
	logic commit_reg;
	logic invalid_reg;
	logic [UBL_DATA_W-1:0] rdata_reg;

	wire logic [7:0] addr8;
	wire logic selInt;
	wire logic selFrac;
	wire logic selLcr;
	wire logic selStatus;
	wire logic charBusy;
	wire logic doCommit;
	wire logic zeroDiv;
	wire logic badFrac;
	wire logic [UBL_DATA_W-1:0] statusWord;
	wire logic [UBL_DATA_W-1:0] readWord;

	assign addr8 = 8'(regAddr);
	assign selInt = (addr8 == UBL_OFS_INT);
	assign selFrac = (addr8 == UBL_OFS_FRAC);
	assign selLcr = (addr8 == UBL_OFS_LCR);
	assign selStatus = (addr8 == UBL_OFS_STATUS);
	assign charBusy = txBusy || rxBusy;
	assign doCommit = pending_reg && !charBusy;
	assign zeroDiv = (intLive_reg == UBL_INT_RESET);
	assign badFrac = (intLive_reg == UBL_INT_MAX) && (fracLive_reg != UBL_FRAC_RESET);

	assign statusWord = {29'h00000000, badFrac, zeroDiv, pending_reg};
	assign readWord = selInt ? {16'h0000, intShadow_reg}
		: selFrac ? {26'h0000000, fracShadow_reg}
		: selLcr ? {24'h000000, lcrShadow_reg}
		: selStatus ? statusWord
		: '0;

	always_comb
	begin
		pending_next = pending_reg;
		if (doCommit)
			pending_next = 1'b0;
		if (regWrite && selLcr)
			pending_next = 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			intShadow_reg <= UBL_INT_RESET;
			fracShadow_reg <= UBL_FRAC_RESET;
			lcrShadow_reg <= UBL_LCR_RESET;
		end
		else if (regWrite)
		begin
			if (selInt)
				intShadow_reg <= regWdata[UBL_INT_W-1:0];
			if (selFrac)
				fracShadow_reg <= regWdata[UBL_FRAC_W-1:0];
			if (selLcr)
				lcrShadow_reg <= regWdata[UBL_LCR_W-1:0];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			intLive_reg <= UBL_INT_RESET;
			fracLive_reg <= UBL_FRAC_RESET;
			lcrLive_reg <= UBL_LCR_RESET;
		end
		else if (doCommit)
		begin
			intLive_reg <= intShadow_reg;
			fracLive_reg <= fracShadow_reg;
			lcrLive_reg <= lcrShadow_reg;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			pending_reg <= 1'b0;
			commit_reg <= 1'b0;
			invalid_reg <= 1'b0;
			rdata_reg <= '0;
		end
		else
		begin
			pending_reg <= pending_next;
			commit_reg <= doCommit;
			invalid_reg <= zeroDiv || badFrac;
			rdata_reg <= regRead ? readWord : '0;
		end
	end

	assign regRdata = rdata_reg;
	assign commitPulse = commit_reg;
	assign divisorInvalid = invalid_reg;

	ubl_baud_gen u_baud
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.load(commit_reg),
		.divInt(intLive_reg),
		.divFrac(fracLive_reg),
		.baudTick(baudTick)
	);

	ubl_frame_cfg u_frame
	(
		.sys_clk(sys_clk),
		.resetn(resetn),
		.lineCtrl(lcrLive_reg),
		.dataBits(dataBits),
		.parityOn(parityOn),
		.parityEven(parityEven),
		.parityStick(parityStick),
		.stickValue(stickValue),
		.twoStopBits(twoStopBits),
		.fifoEnable(fifoEnable),
		.sendBreak(sendBreak)
	);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	a_reset_zero: assert property ($rose(resetn) |-> intShadow_reg == UBL_INT_RESET
		&& fracShadow_reg == UBL_FRAC_RESET && lcrLive_reg == UBL_LCR_RESET)
		else $error("registers not zero after reset");
	a_int_write: assert property (regWrite && selInt |=> intShadow_reg == $past(regWdata[15:0]))
		else $error("integer divisor write lost");
	a_frac_write: assert property (regWrite && selFrac |=>
		regRdata == '0 && fracShadow_reg == $past(regWdata[5:0]))
		else $error("fractional divisor write lost");
	a_lcr_reserved: assert property (regRead && selLcr |=> regRdata[31:8] == 24'h000000
		&& regRdata[7:0] == $past(lcrShadow_reg))
		else $error("line control readback wrong");
	a_hold_busy: assert property (charBusy |=> $stable(intLive_reg) && $stable(fracLive_reg)
		&& $stable(lcrLive_reg))
		else $error("divisor changed during a character");
	a_commit_idle: assert property (pending_reg && !charBusy |=> !pending_reg
		|| $past(regWrite && selLcr))
		else $error("pending commit not taken while idle");
	a_commit_copy: assert property (doCommit |=> intLive_reg == $past(intShadow_reg)
		&& fracLive_reg == $past(fracShadow_reg) && lcrLive_reg == $past(lcrShadow_reg))
		else $error("commit did not copy all three values");
	a_lcr_arms: assert property (regWrite && selLcr |=> pending_reg)
		else $error("line control write did not arm commit");
	a_zero_flag: assert property (zeroDiv |=> divisorInvalid)
		else $error("zero divisor not flagged");

	a_bad_frac_flag: assert property (badFrac |=> divisorInvalid)
		else $error("maximum divisor with fraction not flagged");

	a_valid_flag: assert property (!zeroDiv && !badFrac |=> !divisorInvalid)
		else $error("valid divisor flagged invalid");

	a_int_read: assert property (regRead && selInt |=>
		regRdata == {16'h0000, $past(intShadow_reg)})
		else $error("integer divisor readback wrong");

	a_frac_read: assert property (regRead && selFrac |=>
		regRdata == {26'h0000000, $past(fracShadow_reg)})
		else $error("fractional divisor readback wrong");

	a_status_read: assert property (regRead && selStatus |=>
		regRdata == {29'h00000000, $past(badFrac), $past(zeroDiv), $past(pending_reg)})
		else $error("status readback wrong");

	a_unmapped_read: assert property (regRead && !(selInt || selFrac || selLcr || selStatus)
		|=> regRdata == '0)
		else $error("unmapped address read not zero");

	a_rdata_idle: assert property (!regRead |=> regRdata == '0)
		else $error("read data present without a read");

	a_lcr_write: assert property (regWrite && selLcr |=>
		lcrShadow_reg == $past(regWdata[7:0]))
		else $error("line control write lost");

	a_shadow_hold: assert property (!regWrite |=> $stable(intShadow_reg)
		&& $stable(fracShadow_reg) && $stable(lcrShadow_reg))
		else $error("shadow register changed without a write");

	a_live_hold: assert property (!doCommit |=> $stable(intLive_reg)
		&& $stable(fracLive_reg) && $stable(lcrLive_reg))
		else $error("live register changed without a commit");

	a_commit_pulse: assert property (doCommit |=> commitPulse)
		else $error("commit pulse missing");

	a_no_commit: assert property (!doCommit |=> !commitPulse)
		else $error("commit pulse without a commit");

	a_busy_no_pulse: assert property (charBusy |=> !commitPulse)
		else $error("commit during a character");

	a_pending_hold: assert property (!pending_reg && !(regWrite && selLcr) |=> !pending_reg)
		else $error("commit armed without line control write");

	a_frame_follow: assert property (commitPulse |=>
		dataBits == UBL_MIN_DATA_BITS + {2'b00, $past(lcrLive_reg[6:5])})
		else $error("framing not taken from committed word");

	a_load_no_tick: assert property (commitPulse |-> !baudTick)
		else $error("tick during divisor load");

	a_zero_div_tick: assert property (zeroDiv |-> !baudTick)
		else $error("tick with zero live divisor");

endmodule

// ---- bench/ubl_top_bench.sv ----
// Self-checking bench for the baud divisor and line-control block.
// Assumes the register map and commit timing given in the design notes.
`timescale 1ns/1ns
module ubl_top_bench
	import ubl_pkg::*;
;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [UBL_DATA_W-1:0] regWdata = 32'h0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic txBusy = 1'b0;
	logic rxBusy = 1'b0;
	logic [UBL_DATA_W-1:0] regRdata;
	logic baudTick, commitPulse, divisorInvalid, parityOn, parityEven, parityStick;
	logic stickValue, twoStopBits, fifoEnable, sendBreak;
	logic [3:0] dataBits;
	logic [31:0] seed = 32'h06687DF0;
	logic [31:0] expQ[$];
	logic rdSeen = 1'b0;
	int badCount = 0;
	int nCompared = 0;
	int commitCnt = 0;

	always #2 sys_clk = ~sys_clk;

	ubl_top #(.ADDR_W(8)) ubl_top_inst (.sys_clk(sys_clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .txBusy(txBusy), .rxBusy(rxBusy), .baudTick(baudTick),
		.commitPulse(commitPulse), .divisorInvalid(divisorInvalid), .dataBits(dataBits),
		.parityOn(parityOn), .parityEven(parityEven), .parityStick(parityStick),
		.stickValue(stickValue), .twoStopBits(twoStopBits), .fifoEnable(fifoEnable),
		.sendBreak(sendBreak));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			badCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic testDone();
		$display("Compared %0d, mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Read data stand only in the cycle after the read strobe
	always @(posedge sys_clk)
	begin
		if (rdSeen)
			check("regRdata", regRdata, expQ.pop_front());
		if (commitPulse === 1'b1)
			commitCnt++;
		rdSeen <= regRead;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		expQ.push_back(e);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
	endtask

	task automatic setCfg(input logic [15:0] di, input logic [5:0] df, input logic [7:0] lc);
		int c0;
		wr(UBL_OFS_INT, {16'h0, di});
		wr(UBL_OFS_FRAC, {26'h0, df});
		c0 = commitCnt;
		wr(UBL_OFS_LCR, {24'h0, lc});
		repeat (4) @(posedge sys_clk);
		check("commitPulse", commitCnt - c0, 1);
	endtask

	// Cycles spanned by 64 tick periods, sampled away from the active edge
	task automatic span64(input int exp);
		int n, c;
		@(negedge sys_clk);
		for (c = 0; c < 300 && baudTick !== 1'b1; c++)
			@(negedge sys_clk);
		n = 0;
		c = 0;
		while (n < 64 && c < 9000)
		begin
			@(negedge sys_clk);
			c++;
			if (baudTick === 1'b1)
				n++;
		end
		check("tickSpan", c, exp);
	endtask

	initial
	begin
		repeat (40000) @(posedge sys_clk);
		badCount++;
		testDone();
	end

	initial
	begin
		int i, c0, n;
		logic [7:0] lc;
		logic [15:0] tDi[5] = '{16'h1, 16'h1, 16'h3, 16'h4, 16'h11};
		logic [5:0] tDf[5] = '{6'h0, 6'h5, 6'h10, 6'h0, 6'h17};
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(UBL_OFS_INT, 32'h0);
		rd(UBL_OFS_FRAC, 32'h0);
		rd(UBL_OFS_LCR, 32'h0);
		check("frame", {dataBits, parityOn, parityStick, sendBreak}, {4'h5, 3'h0});
		for (i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			wr(UBL_OFS_INT, seed);
			wr(UBL_OFS_FRAC, seed);
			wr(8'h14, 32'hFFFFFFFF);
			rd(UBL_OFS_INT, seed & 32'hFFFF);
			rd(UBL_OFS_FRAC, seed & 32'h3F);
			rd(8'h14, 32'h0);
			wr(UBL_OFS_LCR, seed & 32'hFF);
			rd(UBL_OFS_LCR, seed & 32'hFF);
		end
		for (i = 0; i < 5; i++)
		begin
			setCfg(tDi[i], tDf[i], 8'h70);
			check("divisorInvalid", divisorInvalid, 1'b0);
			span64(64 * tDi[i] + tDf[i]);
		end
		setCfg(16'h0, 6'h5, 8'h60);
		check("divisorInvalid", divisorInvalid, 1'b1);
		rd(UBL_OFS_STATUS, 32'h2);
		n = 0;
		repeat (200)
		begin
			@(negedge sys_clk);
			if (baudTick !== 1'b0)
				n++;
		end
		check("zeroTicks", n, 0);
		setCfg(16'hFFFF, 6'h1, 8'h60);
		check("divisorInvalid", divisorInvalid, 1'b1);
		rd(UBL_OFS_STATUS, 32'h4);
		setCfg(16'h4, 6'h0, 8'h60);
		txBusy <= 1'b1;
		c0 = commitCnt;
		wr(UBL_OFS_INT, 32'h8);
		span64(256);
		wr(UBL_OFS_LCR, 32'h20);
		rd(UBL_OFS_STATUS, 32'h1);
		txBusy <= 1'b0;
		rxBusy <= 1'b1;
		repeat (20) @(posedge sys_clk);
		check("commitPulse", commitCnt - c0, 0);
		check("dataBits", dataBits, 4'h8);
		rxBusy <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check("commitPulse", commitCnt - c0, 1);
		check("dataBits", dataBits, 4'h6);
		span64(512);
		for (i = 0; i < 32; i++)
		begin
			seed = xs(seed);
			lc = {i[2], i[1:0], seed[1:0], i[3], i[4], seed[2]};
			setCfg(16'h1, 6'h0, lc);
			rd(UBL_OFS_LCR, {24'h0, lc});
			check("dataBits", dataBits, 4'h5 + lc[6:5]);
			check("parity", {parityOn, parityEven, parityStick, stickValue},
				{lc[1], lc[2], lc[1] & lc[7], ~lc[2]});
			check("misc", {twoStopBits, fifoEnable, sendBreak}, {lc[3], lc[4], lc[0]});
		end
		repeat (4) @(posedge sys_clk);
		testDone();
	end
endmodule
